// ---- ibpe_pkg.sv ----
package ibpe_pkg;

   // Bus sampling clock and nominal half period of the generated clock
   localparam int LINK_PERIOD_PS = 12000;
   localparam int SCL_HALF_NS = 5000;
   localparam int SCL_HALF_CYC =
      (SCL_HALF_NS * 1000 + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
   localparam logic [9:0] HALF_CNT = 10'(SCL_HALF_CYC);

   // Bit counter values in the low phase after the eighth and ninth clocks; extension code; shift reset value
   localparam logic [3:0] BIT_ACK = 4'h8;
   localparam logic [3:0] BIT_LAST = 4'h9;
   localparam logic [3:0] EXT_CODE = 4'hF;
   localparam logic [7:0] SHIFT_RESET = 8'h00;

   typedef struct packed {
      logic interface_enable;
      logic ack_enable;
      logic wait_timing_select;
      logic stop_interrupt_enable;
      logic [7:0] local_slave_address;
   } ibpe_ctrl_t;

   typedef struct packed {
      logic start_detected;
      logic stop_detected;
      logic ack_detected;
      logic transmit_receive_flag;
      logic slave_selected;
      logic extension_code;
      logic master_active;
      logic in_wait;
   } ibpe_status_t;

   typedef enum logic [2:0] {
      M_IDLE, M_START, M_LOW, M_HIGH, M_RSTA, M_RSTH, M_STOP1, M_STOP2
   } ibpe_mstate_t;

endpackage : ibpe_pkg

// ---- ibpe_engine.sv ----
// Functional notes
// - Both lines driven low only, pulled up outside
// - Start is data falling while clock high
// - Start emitted after stop; start flag set
// - Seven bits after start form the address
// - Slave selected on match until start/stop
// - Slave interrupts on own address or extension
// - Address and direction shifted from shift register
// - Direction bit zero writes, one reads
// - Receiver pulls data low on ninth clock
// - Transmitter samples ninth clock into ack flag
// - Master receiver withholds ack on last byte
// - Master ends failed transfer by stop/restart
// - Ack enable drives or suppresses data ack
// - Direction flag updated on eighth bit
// - Own address acked regardless of ack enable
// - Eight-clock wait: ack if enabled before release
// - Nine-clock wait: ack if already enabled
// - Stop is data rising while clock high
// - Stop trigger emits stop; stop flag, interrupt
// - Waiting party holds clock low
// - Release by write, release bit, start, stop (start and stop release the wait only when master)
`timescale 1ns/1ps
module ibpe_engine
   import ibpe_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire ibpe_ctrl_t ctrl,
   input wire logic start_trigger,
   input wire logic stop_trigger,
   input wire logic wait_release,
   input wire logic shift_wr,
   input wire logic [7:0] shift_wdata,
   output ibpe_status_t status,
   output logic [7:0] shift_rdata,
   output logic bus_interrupt_request,
   input wire logic bus_sample_clk,
   input wire logic serial_clock_pin_in,
   output logic serial_clock_pin_out,
   output logic serial_clock_pin_oe,
   input wire logic serial_data_pin_in,
   output logic serial_data_pin_out,
   output logic serial_data_pin_oe
);

   // ---------------- main clock side ----------------
   ibpe_ctrl_t ctrl_q;
   logic [3:0] ev_tog;
   logic [7:0] wdata_q;
   ibpe_status_t st_s1, st_s2;
   logic [7:0] rd_s1, rd_s2;
   logic [2:0] irq_s;
   ibpe_status_t st_link;
   logic [7:0] shreg;
   logic irq_tog;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= '0;
      end else begin
         ctrl_q <= ctrl;
      end
   end

   // Events cross as toggles: write, release, stop, start
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ev_tog <= 4'h0;
         wdata_q <= SHIFT_RESET;
      end else begin
         ev_tog <= ev_tog ^ {shift_wr, wait_release, stop_trigger,
                             start_trigger};
         if (shift_wr) begin
            wdata_q <= shift_wdata;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_s1 <= '0;
         st_s2 <= '0;
         rd_s1 <= SHIFT_RESET;
         rd_s2 <= SHIFT_RESET;
         irq_s <= 3'h0;
         bus_interrupt_request <= 1'b0;
      end else begin
         st_s1 <= st_link;
         st_s2 <= st_s1;
         rd_s1 <= shreg;
         rd_s2 <= rd_s1;
         irq_s <= {irq_s[1:0], irq_tog};
         bus_interrupt_request <= irq_s[2] ^ irq_s[1];
      end
   end

   assign status = st_s2;
   assign shift_rdata = rd_s2;

   // ---------------- bus sampling side ----------------
   ibpe_ctrl_t lc_s1, lc;
   logic [3:0] ev_s1, ev_s2, ev_s3;
   logic [2:0] scl_s, sda_s;
   logic ev_start, ev_stop, ev_wrel, ev_write;
   logic en;
   logic scl_rise, scl_fall, start_ev, stop_ev;
   logic [3:0] bitcnt;
   logic addr_phase, selected, trc, ackd, ext, std, spd, busy;
   logic hold, master, scl_oe, sda_oe, pin_low;
   ibpe_mstate_t mst;
   logic [9:0] tmr;
   logic addr_hit, ext_hit, fall8, fall9, next_sel, involved;
   logic tx_now, rx_ack, release_ev, wait_go, irq_ev, half_done;
   logic next_scl_oe, next_sda_oe;

   always_ff @(posedge bus_sample_clk or negedge rst_n) begin
      if (!rst_n) begin
         lc_s1 <= '0;
         lc <= '0;
         ev_s1 <= 4'h0;
         ev_s2 <= 4'h0;
         ev_s3 <= 4'h0;
         scl_s <= 3'h7;
         sda_s <= 3'h7;
      end else begin
         lc_s1 <= ctrl_q;
         lc <= lc_s1;
         ev_s1 <= ev_tog;
         ev_s2 <= ev_s1;
         ev_s3 <= ev_s2;
         scl_s <= {scl_s[1:0], serial_clock_pin_in};
         sda_s <= {sda_s[1:0], serial_data_pin_in};
      end
   end

   always_comb begin
      {ev_write, ev_wrel, ev_stop, ev_start} = ev_s2 ^ ev_s3;
      en = lc.interface_enable;
      scl_rise = scl_s[1] & ~scl_s[2];
      scl_fall = ~scl_s[1] & scl_s[2];
      start_ev = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
      stop_ev = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
      addr_hit = shreg[7:1] == lc.local_slave_address[7:1];
      ext_hit = shreg[7:4] == EXT_CODE;
      fall8 = scl_fall & (bitcnt == BIT_ACK);
      fall9 = scl_fall & (bitcnt == BIT_LAST);
      next_sel = addr_phase ? (~master & addr_hit) : selected;
      involved = master | next_sel;
      tx_now = addr_phase ? master : trc & (master | selected);
      // Own address always acked, data only with ack enable
      rx_ack = ~tx_now & (master | selected) &
               (addr_phase ? selected : lc.ack_enable);
      release_ev = ev_write | ev_wrel |
                   (master & (ev_start | ev_stop));
      wait_go = involved &
                ((fall8 & ~lc.wait_timing_select) |
                 (fall9 & lc.wait_timing_select));
      irq_ev = (fall8 & addr_phase & ~master & (addr_hit | ext_hit)) |
               wait_go | (mst == M_START & half_done) |
               (stop_ev & lc.stop_interrupt_enable);
      half_done = tmr >= HALF_CNT;
      st_link = '{std, spd, ackd, trc, selected, ext, master, hold};
   end

   // Bit position and address phase tracking
   always_ff @(posedge bus_sample_clk or negedge rst_n) begin
      if (!rst_n) begin
         bitcnt <= 4'h0;
         addr_phase <= 1'b0;
         selected <= 1'b0;
         busy <= 1'b0;
      end else if (!en) begin
         bitcnt <= 4'h0;
         addr_phase <= 1'b0;
         selected <= 1'b0;
         busy <= 1'b0;
      end else if (start_ev) begin
         bitcnt <= 4'h0;
         addr_phase <= 1'b1;
         selected <= 1'b0;
         busy <= 1'b1;
      end else if (stop_ev) begin
         addr_phase <= 1'b0;
         selected <= 1'b0;
         busy <= 1'b0;
      end else if (scl_rise && bitcnt != BIT_LAST) begin
         bitcnt <= bitcnt + 4'h1;
      end else if (fall8) begin
         selected <= next_sel;
      end else if (fall9) begin
         bitcnt <= 4'h0;
         addr_phase <= 1'b0;
      end
   end

   // Shift register, direction, ack and extension flags
   always_ff @(posedge bus_sample_clk or negedge rst_n) begin
      if (!rst_n) begin
         shreg <= SHIFT_RESET;
         trc <= 1'b0;
         ackd <= 1'b0;
         ext <= 1'b0;
      end else if (ev_write) begin
         shreg <= wdata_q;
      end else if (!en) begin
         trc <= 1'b0;
         ackd <= 1'b0;
         ext <= 1'b0;
      end else if (start_ev) begin
         ext <= 1'b0;
         ackd <= 1'b0;
      end else if (scl_rise && bitcnt < BIT_ACK) begin
         shreg <= {shreg[6:0], sda_s[1]};
      end else if (scl_rise && bitcnt == BIT_ACK && tx_now) begin
         ackd <= ~sda_s[1];
      end else if (fall8 && addr_phase) begin
         // Direction bit: master sends on 0, slave sends on 1
         trc <= master ? ~shreg[0] : shreg[0];
         ext <= ~master & ext_hit;
      end
   end

   // Start and stop detected flags
   always_ff @(posedge bus_sample_clk or negedge rst_n) begin
      if (!rst_n) begin
         std <= 1'b0;
         spd <= 1'b0;
      end else if (!en) begin
         std <= 1'b0;
         spd <= 1'b0;
      end else if (start_ev) begin
         std <= 1'b1;
         spd <= 1'b0;
      end else if (stop_ev) begin
         std <= 1'b0;
         spd <= 1'b1;
      end
   end

   // Wait state; a new wait wins over a release in the same cycle
   always_ff @(posedge bus_sample_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold <= 1'b0;
      end else if (!en) begin
         hold <= 1'b0;
      end else if (wait_go || (mst == M_START && half_done)) begin
         hold <= 1'b1;
      end else if (release_ev) begin
         hold <= 1'b0;
      end
   end

   // Master clock generation and start/stop sequencing
   always_ff @(posedge bus_sample_clk or negedge rst_n) begin
      if (!rst_n) begin
         mst <= M_IDLE;
         tmr <= 10'h000;
         master <= 1'b0;
      end else if (!en) begin
         mst <= M_IDLE;
         tmr <= 10'h000;
         master <= 1'b0;
      end else begin
         tmr <= half_done ? tmr : tmr + 10'h001;
         if (mst == M_IDLE) begin
            tmr <= 10'h000;
            if (ev_start && !busy) begin
               mst <= M_START;
            end
         end else if (mst == M_START) begin
            if (half_done) begin
               mst <= M_LOW;
               tmr <= 10'h000;
               master <= 1'b1;
            end
         end else if (mst == M_LOW) begin
            if (ev_stop) begin
               mst <= M_STOP1;
               tmr <= 10'h000;
            end else if (ev_start) begin
               mst <= M_RSTA;
               tmr <= 10'h000;
            end else if (half_done && !hold) begin
               mst <= M_HIGH;
               tmr <= 10'h000;
            end
         end else if (mst == M_HIGH || mst == M_RSTH || mst == M_STOP2) begin
            // High time counts only once the line is seen high
            if (!scl_s[1]) begin
               tmr <= 10'h000;
            end else if (half_done) begin
               tmr <= 10'h000;
               if (mst == M_HIGH) begin
                  mst <= M_LOW;
               end else if (mst == M_RSTH) begin
                  mst <= M_START;
               end else begin
                  mst <= M_IDLE;
                  master <= 1'b0;
               end
            end
         end else if (half_done) begin
            tmr <= 10'h000;
            mst <= (mst == M_RSTA) ? M_RSTH : M_STOP2;
         end
      end
   end

   // Open-drain drive enables
   always_comb begin
      next_scl_oe = hold | (mst == M_LOW) | (mst == M_RSTA) |
                    (mst == M_STOP1);
      next_sda_oe = sda_oe;
      if (mst == M_START || mst == M_STOP1) begin
         next_sda_oe = 1'b1;
      end else if (mst == M_STOP2) begin
         // Data released once clock high time is over: the stop edge
         next_sda_oe = ~(scl_s[1] & half_done);
      end else if (mst == M_RSTA || mst == M_RSTH) begin
         next_sda_oe = 1'b0;
      end else if (!scl_s[1]) begin
         if (bitcnt == BIT_ACK) begin
            next_sda_oe = rx_ack;
         end else begin
            next_sda_oe = (bitcnt < BIT_ACK) & tx_now & ~shreg[7];
         end
      end
   end

   always_ff @(posedge bus_sample_clk or negedge rst_n) begin
      if (!rst_n) begin
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         pin_low <= 1'b0;
      end else begin
         scl_oe <= en & next_scl_oe;
         sda_oe <= en & next_sda_oe;
         pin_low <= 1'b0;
      end
   end

   // Pins only ever pull low
   assign serial_clock_pin_out = pin_low;
   assign serial_data_pin_out = pin_low;
   assign serial_clock_pin_oe = scl_oe;
   assign serial_data_pin_oe = sda_oe;

   always_ff @(posedge bus_sample_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_tog <= 1'b0;
      end else if (en && irq_ev) begin
         irq_tog <= ~irq_tog;
      end
   end

endmodule : ibpe_engine

// ---- ibpe_engine_chk.sv ----
`timescale 1ns/1ps
module ibpe_engine_chk
   import ibpe_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire ibpe_ctrl_t ctrl,
   input wire ibpe_status_t status,
   input wire logic bus_interrupt_request,
   input wire logic bus_sample_clk,
   input wire logic serial_clock_pin_in,
   input wire logic serial_clock_pin_out,
   input wire logic serial_clock_pin_oe,
   input wire logic serial_data_pin_in,
   input wire logic serial_data_pin_out,
   input wire logic serial_data_pin_oe
);
   logic en;
   assign en = ctrl.interface_enable;
   default clocking @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   a_pins_low_only: assert property (
      @(posedge bus_sample_clk)
      !serial_clock_pin_out && !serial_data_pin_out)
      else $error("pin driven high");
   a_irq_one_cycle: assert property (
      bus_interrupt_request |=> !bus_interrupt_request)
      else $error("interrupt longer than one cycle");
   a_start_clears_stop: assert property (
      $rose(status.start_detected) |-> !status.stop_detected)
      else $error("stop flag kept after start");
   a_stop_clears_start: assert property (
      $rose(status.stop_detected) |-> !status.start_detected)
      else $error("start flag kept after stop");
   a_wait_holds_clock: assert property (
      $rose(status.in_wait) |-> ##[0:4] serial_clock_pin_oe)
      else $error("wait without clock held low");
   a_select_after_start: assert property (
      $rose(status.slave_selected) |-> status.start_detected)
      else $error("selected without start");
   a_select_acks: assert property (
      $rose(status.slave_selected) |-> ##[0:8] serial_data_pin_oe)
      else $error("own address not acknowledged");
   a_stop_irq_masked: assert property (
      $rose(status.stop_detected) && !ctrl.stop_interrupt_enable
      |-> !bus_interrupt_request [*6])
      else $error("stop interrupt while disabled");
   a_start_seen: assert property (
      en && serial_clock_pin_in && $fell(serial_data_pin_in)
      |-> ##[1:24] status.start_detected)
      else $error("start not detected");
   a_stop_seen: assert property (
      en && serial_clock_pin_in && $rose(serial_data_pin_in)
      |-> ##[1:24] status.stop_detected)
      else $error("stop not detected");
endmodule : ibpe_engine_chk
bind ibpe_engine ibpe_engine_chk i_ibpe_engine_chk (.*);

// ---- ibpe_peer.sv ----
`timescale 1ns/1ps
module ibpe_peer (
   input wire logic scl,
   input wire logic sda,
   output logic scl_oe,
   output logic sda_oe
);
   localparam int T = 240;
   logic ack_on = 1'b0;
   logic sda_ack = 1'b0;
   logic drv = 1'b0;
   logic [7:0] rx = 8'h00;
   logic [7:0] last = 8'h00;
   int cnt = 0;
   int stuck = 0;
   initial scl_oe = 1'b0;
   assign sda_oe = drv | sda_ack;
   always @(negedge sda) if (scl) cnt <= 0;
   always @(posedge scl) begin
      rx <= {rx[6:0], sda};
      if (cnt == 7) last <= {rx[6:0], sda};
      cnt <= (cnt == 8) ? 0 : cnt + 1;
   end
   always @(negedge scl) sda_ack <= ack_on && cnt == 8;
   task automatic bit_io(input logic b, output logic s);
      int i;
      drv = !b;
      #T;
      scl_oe = 1'b0;
      for (i = 0; i < 4000 && !scl; i++) #12;
      if (!scl) stuck++;
      #T;
      s = sda;
      scl_oe = 1'b1;
   endtask : bit_io
   task automatic start();
      drv = 1'b1;
      #T;
      scl_oe = 1'b1;
      #T;
   endtask : start
   task automatic stop();
      drv = 1'b1;
      #T;
      scl_oe = 1'b0;
      #T;
      drv = 1'b0;
      #T;
   endtask : stop
endmodule : ibpe_peer

// ---- ibpe_engine_bench.sv ----
`timescale 1ns/1ps
module ibpe_engine_bench;
   import ibpe_pkg::*;
   logic mclk = 1'b0;
   logic lclk = 1'b0;
   logic rst_n = 1'b0;
   ibpe_ctrl_t ctrl = '{1'b0, 1'b0, 1'b0, 1'b0, 8'hA4};
   logic sta = 1'b0;
   logic sto = 1'b0;
   logic rel = 1'b0;
   logic wr = 1'b0;
   logic [7:0] wdata = 8'h00;
   ibpe_status_t st;
   logic [7:0] rdata;
   logic irq, scl_oe, sda_oe, p_scl, p_sda;
   wire scl = !(scl_oe | p_scl);
   wire sda = !(sda_oe | p_sda);
   int miscompares = 0;
   int compares = 0;
   ibpe_engine i_ibpe_engine (.mclk(mclk), .rst_n(rst_n), .ctrl(ctrl),
      .start_trigger(sta), .stop_trigger(sto), .wait_release(rel),
      .shift_wr(wr), .shift_wdata(wdata), .status(st),
      .shift_rdata(rdata), .bus_interrupt_request(irq),
      .bus_sample_clk(lclk), .serial_clock_pin_in(scl),
      .serial_clock_pin_out(), .serial_clock_pin_oe(scl_oe),
      .serial_data_pin_in(sda), .serial_data_pin_out(),
      .serial_data_pin_oe(sda_oe));
   ibpe_peer i_ibpe_peer (.scl(scl), .sda(sda), .scl_oe(p_scl),
      .sda_oe(p_sda));
   initial forever #2.5 mclk = ~mclk;
   initial begin
      #3.7;
      forever #6 lclk = ~lclk;
   end
   task automatic conclude();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : conclude
   task automatic chk(input string n, input logic [7:0] e, g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic await_irq(input int n);
      int i;
      for (i = 0; i < n && irq !== 1'b1; i++) @(negedge mclk);
      chk("interrupt", 8'h01, 8'(irq));
      if (irq !== 1'b1) conclude();
      repeat (4) @(posedge mclk);
   endtask : await_irq
   task automatic send8(input logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) i_ibpe_peer.bit_io(v[i], s);
   endtask : send8
   task automatic slave_write();
      logic s;
      i_ibpe_peer.start();
      send8(8'hA4);
      await_irq(400);
      chk("selected", 8'h01, 8'(st.slave_selected));
      chk("direction", 8'h00, 8'(st.transmit_receive_flag));
      chk("address", 8'hA4, rdata);
      @(posedge mclk) rel <= 1'b1;
      @(posedge mclk) rel <= 1'b0;
      i_ibpe_peer.bit_io(1'b1, s);
      chk("address ack", 8'h00, 8'(s));
      send8(8'h3C);
      await_irq(400);
      chk("data", 8'h3C, rdata);
      @(posedge mclk) ctrl.ack_enable <= 1'b1;
      wr <= 1'b1;
      wdata <= 8'hFF;
      @(posedge mclk) wr <= 1'b0;
      i_ibpe_peer.bit_io(1'b1, s);
      chk("data ack", 8'h00, 8'(s));
      send8(8'hC3);
      await_irq(400);
      @(posedge mclk) ctrl.ack_enable <= 1'b0;
      rel <= 1'b1;
      @(posedge mclk) rel <= 1'b0;
      i_ibpe_peer.bit_io(1'b1, s);
      chk("data nack", 8'h01, 8'(s));
      i_ibpe_peer.stop();
      repeat (30) @(posedge mclk);
      chk("stop flag", 8'h01, 8'(st.stop_detected));
   endtask : slave_write
   task automatic slave_other();
      logic s;
      i_ibpe_peer.start();
      send8(8'hB4);
      i_ibpe_peer.bit_io(1'b1, s);
      chk("foreign ack", 8'h01, 8'(s));
      chk("foreign sel", 8'h00, 8'(st.slave_selected));
      i_ibpe_peer.stop();
   endtask : slave_other
   task automatic master_write();
      @(posedge mclk) ctrl.wait_timing_select <= 1'b1;
      ctrl.stop_interrupt_enable <= 1'b1;
      i_ibpe_peer.ack_on = 1'b1;
      repeat (20) @(posedge mclk);
      sta <= 1'b1;
      @(posedge mclk) sta <= 1'b0;
      await_irq(3000);
      chk("start flag", 8'h01, 8'(st.start_detected));
      chk("master", 8'h01, 8'(st.master_active));
      @(posedge mclk) wr <= 1'b1;
      wdata <= 8'hA4;
      @(posedge mclk) wr <= 1'b0;
      await_irq(25000);
      chk("sent", 8'hA4, i_ibpe_peer.last);
      chk("ack flag", 8'h01, 8'(st.ack_detected));
      chk("transmit", 8'h01, 8'(st.transmit_receive_flag));
      @(posedge mclk) sto <= 1'b1;
      @(posedge mclk) sto <= 1'b0;
      await_irq(5000);
      chk("stop", 8'h01, 8'(st.stop_detected));
   endtask : master_write
   initial begin
      repeat (20) @(posedge mclk);
      rst_n <= 1'b1;
      @(posedge mclk) ctrl.interface_enable <= 1'b1;
      repeat (20) @(posedge mclk);
      slave_write();
      slave_other();
      master_write();
      chk("peer stuck", 8'h00, 8'(i_ibpe_peer.stuck));
      conclude();
   end
endmodule : ibpe_engine_bench
